/* inc/fpr_pkg.sv */
// Constants, register map and state type of the feeder protection block
package fpr_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS       = 1000000;  // Timers count in milliseconds
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] A_STAGE0 = 8'h00;  // Nine stage words, 0x00..0x20
  localparam logic [7:0] A_CFG    = 8'h24;
  localparam logic [7:0] A_ANGLE  = 8'h28;
  localparam logic [7:0] A_DEBLK  = 8'h2c;
  localparam logic [7:0] A_DEAD0  = 8'h30;  // Five shot words, 0x30..0x40
  localparam logic [7:0] A_ROUTE  = 8'h44;
  localparam logic [7:0] A_MAINT  = 8'h48;
  localparam logic [7:0] A_BFAIL  = 8'h4c;
  localparam logic [7:0] A_STATUS = 8'h50;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int F_CFG_OC_INV   = 9;
  localparam int F_CFG_EF_INV   = 10;
  localparam int F_CFG_VMODE    = 11;
  localparam int F_CFG_SHOTS    = 12;  // Three bits
  localparam int F_CFG_SC_BLK   = 15;
  localparam int F_CFG_MAINT_BL = 16;
  localparam int F_SHOT_MASK    = 16;  // Four bits: ext, ef, oc, sc
  localparam int F_SHOT_TRIP    = 20;
  localparam int F_ST_DEF       = 27;
  localparam int F_ST_BF        = 28;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] R_STAGE = 32'h0064_ffff;  // 100 ms, level max
  localparam logic [31:0] R_CFG   = 32'h0000_1000;  // One shot
  localparam logic [31:0] R_ANGLE = 32'h005a_0000;  // Base 0, half 90
  localparam logic [31:0] R_DEBLK = 32'h03e8_ffff;  // Reclaim 1000 ms
  localparam logic [31:0] R_DEAD  = 32'h0011_01f4;  // 500 ms, sc trip
  localparam logic [31:0] R_ROUTE = 32'h0000_01ff;
  localparam logic [15:0] R_MAINT = 16'h03e8;
  localparam logic [15:0] R_PRE   = 16'h0064;
  localparam logic [31:0] R_BFAIL = 32'h0000_0096;  // 150 ms

  // ---------------------------------------------------------------
  // Angles in degrees
  // ---------------------------------------------------------------
  localparam logic [8:0] DEG_HALF = 9'h0b4;
  localparam logic [8:0] DEG_FULL = 9'h168;

  // Inverse-time speed-up: excess current shifted right by this
  localparam int INV_SHIFT   = 4;
  localparam int MAINT_SHIFT = 8;

  // ---------------------------------------------------------------
  // Auto-reclose states
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    AR_IDLE    = 6'h01,
    AR_OPEN    = 6'h02,
    AR_DEAD    = 6'h04,
    AR_CLOSE   = 6'h08,
    AR_RECLAIM = 6'h10,
    AR_FINAL   = 6'h20
  } fpr_ar_t;

endpackage : fpr_pkg

/* verilog/fpr_stage.sv */
// One protection stage: start flag and operate-time timer
`timescale 1ns/1ps
module fpr_stage
  import fpr_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_tick,
  // Condition and settings
  input  wire logic         i_cond,
  input  wire logic         i_inverse,
  input  wire logic [W-1:0] i_meas,
  input  wire logic [W-1:0] i_level,
  input  wire logic [W-1:0] i_time,
  // Result
  output logic              o_start,
  output logic              o_trip
);

  logic [W-1:0] acc_q;
  logic [W-1:0] excess;
  logic [W-1:0] inc;
  logic [W:0]   sum;
  logic         done;

  // Higher overcurrent advances the inverse timer faster
  assign excess = (i_meas > i_level) ? W'(i_meas - i_level) : '0;
  assign inc    = i_inverse ? W'((excess >> INV_SHIFT) + 1'b1) : W'(1);
  assign sum    = {1'b0, acc_q} + {1'b0, inc};
  assign done   = acc_q >= i_time;

  // Timer restarts whenever the condition drops
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_cond) begin
      acc_q <= '0;
    end else if (i_tick && !done) begin
      acc_q <= sum[W] ? '1 : sum[W-1:0];  // Saturate, never wrap
    end
  end

  // Start follows the condition, trip needs expiry too
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_start <= 1'b0;
      o_trip  <= 1'b0;
    end else begin
      o_start <= i_cond;
      o_trip  <= i_cond && done;
    end
  end

endmodule : fpr_stage

/* verilog/fpr_top.sv */
// Feeder protection decision logic, reclose sequencer and register slave
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module fpr_top
  import fpr_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST,
  // Measured quantities (same clock)
  input  wire logic [15:0] I_PHASE_CUR_A,
  input  wire logic [15:0] I_PHASE_CUR_B,
  input  wire logic [15:0] I_PHASE_CUR_C,
  input  wire logic [15:0] I_NEUTRAL_CUR,
  input  wire logic [15:0] I_NEUTRAL_CUR_SENS,
  input  wire logic [15:0] I_RESIDUAL_VOLT,
  input  wire logic [8:0]  I_RESIDUAL_ANGLE,
  // External control pins
  input  wire logic        I_EXTERNAL_CONTROL_ONE,
  input  wire logic        I_EXTERNAL_CONTROL_TWO,
  input  wire logic        I_BREAKER_POSITION_INPUT,
  input  wire logic        I_RECLOSE_INHIBIT_INPUT,
  input  wire logic        I_RECLOSE_CONTROL_INPUT,
  // Avalon-MM slave
  input  wire logic [7:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]  I_AVS_BYTEENABLE,
  output logic [31:0]      O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  // Output relays and status
  output logic             O_HEAVY_TRIP_OUTPUT_ONE,
  output logic             O_HEAVY_TRIP_OUTPUT_TWO,
  output logic             O_UPSTREAM_TRIP,
  output logic             O_BREAKER_CLOSE_OUTPUT,
  output logic             O_START_SIGNAL,
  output logic             O_RECLOSE_BUSY,
  output logic             O_DEFINITE_TRIP_INDICATOR,
  output logic             O_BREAKER_FAIL_ALARM,
  output logic [3:0]       O_DEFINITE_SOURCE,
  output logic             O_MAINT_ALARM,
  output logic             O_MAINT_PREALARM,
  output logic             O_SELF_SUPERVISION_OUTPUT
);

  // ---------------------------------------------------------------
  // Pin synchronisers and millisecond tick
  // ---------------------------------------------------------------
  logic [4:0]  pin_s1_q;
  logic [4:0]  pin_s2_q;
  logic        ctrl_prev_q;
  logic        brk_prev_q;
  logic [31:0] div_q;
  logic        tick;

  // Order: ctrl, inhibit, position, ext two, ext one
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      pin_s1_q    <= '0;
      pin_s2_q    <= '0;
      ctrl_prev_q <= 1'b0;
      brk_prev_q  <= 1'b0;
    end else begin
      pin_s1_q    <= {I_RECLOSE_CONTROL_INPUT, I_RECLOSE_INHIBIT_INPUT,
                      I_BREAKER_POSITION_INPUT, I_EXTERNAL_CONTROL_TWO,
                      I_EXTERNAL_CONTROL_ONE};
      pin_s2_q    <= pin_s1_q;
      ctrl_prev_q <= pin_s2_q[4];
      brk_prev_q  <= pin_s2_q[2];
    end
  end

  logic ext_one;
  logic close_inh;
  logic brk_open;
  logic inhibit;
  logic ctrl_rise;
  logic brk_opened;
  assign ext_one    = pin_s2_q[0];
  assign close_inh  = pin_s2_q[1];
  assign brk_open   = pin_s2_q[2];
  assign inhibit    = pin_s2_q[3];
  assign ctrl_rise  = pin_s2_q[4] && !ctrl_prev_q;
  assign brk_opened = pin_s2_q[2] && !brk_prev_q;

  // Divider gives the one-cycle timer enable
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end
  assign tick = div_q == 32'(TICK_CNT - 1);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] stage_q [0:8];
  logic [31:0] dead_q  [0:4];
  logic [31:0] cfg_q;
  logic [31:0] angle_q;
  logic [31:0] deblk_q;
  logic [31:0] route_q;
  logic [31:0] bfail_q;
  logic [15:0] maint_q;
  logic [15:0] pre_q;
  logic        done_q;
  logic        wr_en;
  logic [7:0]  addr;
  logic [31:0] wmask;
  logic [31:0] rdata;

  // One wait cycle per access, answer at the second edge
  assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && !done_q;
  assign wr_en = I_AVS_WRITE && done_q;
  assign addr  = {I_AVS_ADDRESS[7:2], 2'b00};
  assign wmask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
                  {8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (I_AVS_READ || I_AVS_WRITE) && !done_q;
    end
  end

  // Settings storage; unmapped writes fall through
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      for (int k = 0; k < 9; k++) begin
        stage_q[k] <= R_STAGE;
      end
      for (int k = 0; k < 5; k++) begin
        dead_q[k] <= R_DEAD;
      end
      cfg_q   <= R_CFG;
      angle_q <= R_ANGLE;
      deblk_q <= R_DEBLK;
      route_q <= R_ROUTE;
      bfail_q <= R_BFAIL;
      pre_q   <= R_PRE;
    end else if (wr_en) begin
      if (addr < A_CFG) begin
        stage_q[addr[5:2]] <= merge(stage_q[addr[5:2]], I_AVS_WRITEDATA, wmask);
      end
      if (addr >= A_DEAD0 && addr < A_ROUTE) begin
        dead_q[3'(addr[7:2] - A_DEAD0[7:2])] <=
          merge(dead_q[3'(addr[7:2] - A_DEAD0[7:2])], I_AVS_WRITEDATA, wmask);
      end
      if (addr == A_CFG)   cfg_q   <= merge(cfg_q, I_AVS_WRITEDATA, wmask);
      if (addr == A_ANGLE) angle_q <= merge(angle_q, I_AVS_WRITEDATA, wmask);
      if (addr == A_DEBLK) deblk_q <= merge(deblk_q, I_AVS_WRITEDATA, wmask);
      if (addr == A_ROUTE) route_q <= merge(route_q, I_AVS_WRITEDATA, wmask);
      if (addr == A_BFAIL) bfail_q <= merge(bfail_q, I_AVS_WRITEDATA, wmask);
      if (addr == A_MAINT) pre_q   <= 16'(merge({pre_q, 16'h0}, I_AVS_WRITEDATA,
                                                wmask) >> 16);
    end
  end

  // ---------------------------------------------------------------
  // Measurement conditions and stages
  // ---------------------------------------------------------------
  logic [15:0] i_max;
  logic [15:0] i_min;
  logic [15:0] ab_max;
  logic [15:0] ab_min;
  logic [8:0]  ang_d1;
  logic [8:0]  ang_d;
  logic        ang_ok;
  logic        vmode;
  logic [15:0] meas  [0:8];
  logic [8:0]  cond;
  logic [8:0]  inv;
  logic [8:0]  starts;
  logic [8:0]  trips;

  assign ab_max = (I_PHASE_CUR_A > I_PHASE_CUR_B) ? I_PHASE_CUR_A : I_PHASE_CUR_B;
  assign ab_min = (I_PHASE_CUR_A > I_PHASE_CUR_B) ? I_PHASE_CUR_B : I_PHASE_CUR_A;
  assign i_max  = (ab_max > I_PHASE_CUR_C) ? ab_max : I_PHASE_CUR_C;
  assign i_min  = (ab_min < I_PHASE_CUR_C) ? ab_min : I_PHASE_CUR_C;
  assign vmode  = cfg_q[F_CFG_VMODE];

  // Angle distance taken the short way round the circle
  assign ang_d1 = (I_RESIDUAL_ANGLE >= angle_q[8:0]) ?
                  9'(I_RESIDUAL_ANGLE - angle_q[8:0]) :
                  9'(angle_q[8:0] - I_RESIDUAL_ANGLE);
  assign ang_d  = (ang_d1 > DEG_HALF) ? 9'(DEG_FULL - ang_d1) : ang_d1;
  assign ang_ok = ang_d <= angle_q[24:16];

  // Stage order: oc low, high, very high, ef low, high, discontinuity,
  // directional low, high, third voltage stage
  always_comb begin
    for (int k = 0; k < 9; k++) begin
      meas[k] = I_RESIDUAL_VOLT;
    end
    meas[0] = i_max;
    meas[1] = i_max;
    meas[2] = i_max;
    meas[3] = I_NEUTRAL_CUR;
    meas[4] = I_NEUTRAL_CUR;
    meas[5] = 16'(i_max - i_min);
    if (!vmode) begin
      meas[6] = I_NEUTRAL_CUR_SENS;
      meas[7] = I_NEUTRAL_CUR_SENS;
    end
    for (int k = 0; k < 9; k++) begin
      cond[k] = (meas[k] > stage_q[k][15:0]) && !cfg_q[k];
    end
    if (!vmode) begin
      // Shared deblocking voltage and angle window
      cond[6] = cond[6] && (I_RESIDUAL_VOLT > deblk_q[15:0]) && ang_ok;
      cond[7] = cond[7] && (I_RESIDUAL_VOLT > deblk_q[15:0]) && ang_ok;
      cond[8] = 1'b0;
    end
    inv    = '0;
    inv[0] = cfg_q[F_CFG_OC_INV];
    inv[3] = cfg_q[F_CFG_EF_INV];
  end

  // Each stage resets its timer the moment its condition drops
  for (genvar k = 0; k < 9; k++) begin : g_stage
    fpr_stage #(
      .W (16)
    ) u_stage (
      .i_clk     (I_SYS_CLK),
      .i_rst     (I_RST),
      .i_tick    (tick),
      .i_cond    (cond[k]),
      .i_inverse (inv[k]),
      .i_meas    (meas[k]),
      .i_level   (stage_q[k][15:0]),
      .i_time    (stage_q[k][31:16]),
      .o_start   (starts[k]),
      .o_trip    (trips[k])
    );
  end

  // ---------------------------------------------------------------
  // Auto-reclose sequencer
  // ---------------------------------------------------------------
  fpr_ar_t     st_q;
  logic [2:0]  shot_q;
  logic [15:0] ar_cnt_q;
  logic [3:0]  src_q;
  logic [2:0]  sel;
  logic [31:0] word;
  logic [3:0]  grp_s;
  logic [3:0]  grp_t;
  logic [3:0]  hit;
  logic        init;
  logic        blk;
  logic        def_q;
  logic        heavy_one_q;

  // Groups: ext, earth fault, overcurrent, short circuit
  assign grp_s = {ext_one, |{starts[8:6], starts[4:3]}, starts[0], |starts[2:1]};
  assign grp_t = {ext_one, |{trips[8:6], trips[4:3]}, trips[0], |trips[2:1]};
  // Reclaim looks ahead to the configuration of the next shot
  assign sel   = (st_q == AR_IDLE) ? 3'h0 :
                 (st_q == AR_RECLAIM && shot_q < 3'h5) ? shot_q : 3'(shot_q - 3'h1);
  assign word  = dead_q[sel];
  assign hit   = word[F_SHOT_MASK +: 4] & (word[F_SHOT_TRIP] ? grp_t : grp_s);
  assign init  = |hit;
  assign blk   = inhibit || (cfg_q[F_CFG_SC_BLK] && grp_s[0])
                 || (cfg_q[F_CFG_MAINT_BL] && O_MAINT_ALARM);

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      st_q     <= AR_IDLE;
      shot_q   <= 3'h0;
      ar_cnt_q <= '0;
      src_q    <= '0;
    end else begin
      if (tick) ar_cnt_q <= ar_cnt_q + 16'h1;
      case (st_q)
        AR_IDLE: begin
          if ((init || ctrl_rise) && !blk) begin
            st_q   <= AR_OPEN;
            shot_q <= 3'h1;
            src_q  <= hit | {ctrl_rise, 3'h0};
          end
        end
        AR_OPEN: begin
          if (inhibit) st_q <= AR_FINAL;
          else if (brk_open) begin
            st_q     <= AR_DEAD;
            ar_cnt_q <= '0;
          end
        end
        AR_DEAD: begin
          if (inhibit) st_q <= AR_FINAL;
          else if (ar_cnt_q >= word[15:0] && !close_inh) st_q <= AR_CLOSE;
        end
        AR_CLOSE: begin
          if (inhibit) st_q <= AR_FINAL;
          else if (!brk_open) begin
            st_q     <= AR_RECLAIM;
            ar_cnt_q <= '0;
          end
        end
        AR_RECLAIM: begin
          if (init || |trips) begin
            if (init && shot_q < cfg_q[F_CFG_SHOTS +: 3]) begin
              st_q   <= AR_OPEN;
              shot_q <= 3'(shot_q + 3'h1);
            end else begin
              st_q <= AR_FINAL;
            end
          end else if (ar_cnt_q >= deblk_q[31:16]) begin
            st_q <= AR_IDLE;
          end
        end
        AR_FINAL: begin
          // Hold lockout until the breaker is open and faults clear
          if (brk_open && !(|starts)) st_q <= AR_IDLE;
        end
        default: st_q <= AR_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs, definite trip and breaker failure
  // ---------------------------------------------------------------
  logic [15:0] bf_cnt_q;
  logic        bf_q;
  logic        clr_def;
  logic        clr_bf;
  logic        def_set;
  logic [3:0]  dsrc_q;

  assign clr_def = wr_en && addr == A_STATUS && I_AVS_WRITEDATA[F_ST_DEF];
  assign clr_bf  = wr_en && addr == A_STATUS && I_AVS_WRITEDATA[F_ST_BF];
  assign def_set = st_q == AR_FINAL;

  // Relay drive registered so contacts see no glitches
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      heavy_one_q               <= 1'b0;
      O_HEAVY_TRIP_OUTPUT_TWO   <= 1'b0;
      O_START_SIGNAL            <= 1'b0;
      O_BREAKER_CLOSE_OUTPUT    <= 1'b0;
      O_RECLOSE_BUSY            <= 1'b0;
      O_SELF_SUPERVISION_OUTPUT <= 1'b0;
    end else begin
      heavy_one_q <= |(trips & route_q[8:0]) || st_q == AR_OPEN
                     || (st_q == AR_FINAL && !brk_open);
      O_HEAVY_TRIP_OUTPUT_TWO   <= |(trips & route_q[17:9]);
      O_START_SIGNAL            <= |(starts & route_q[26:18]);
      O_BREAKER_CLOSE_OUTPUT    <= st_q == AR_CLOSE && !close_inh;
      O_RECLOSE_BUSY            <= !(st_q inside {AR_IDLE, AR_FINAL});
      O_SELF_SUPERVISION_OUTPUT <= 1'b1;
    end
  end
  assign O_HEAVY_TRIP_OUTPUT_ONE = heavy_one_q;

  // Definite flag: hardware set wins over software clear
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      def_q  <= 1'b0;
      dsrc_q <= '0;
    end else if (def_set) begin
      def_q  <= 1'b1;
      dsrc_q <= src_q;
    end else if (clr_def) begin
      def_q  <= 1'b0;
    end
  end
  assign O_DEFINITE_TRIP_INDICATOR = def_q;
  assign O_DEFINITE_SOURCE         = dsrc_q;

  // Breaker stays closed under trip too long: trip the upstream breaker
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      bf_cnt_q        <= '0;
      O_UPSTREAM_TRIP <= 1'b0;
      bf_q            <= 1'b0;
    end else begin
      if (!heavy_one_q || brk_open) begin
        bf_cnt_q        <= '0;
        O_UPSTREAM_TRIP <= 1'b0;
      end else if (bf_cnt_q >= bfail_q[15:0]) begin
        O_UPSTREAM_TRIP <= 1'b1;
      end else if (tick) begin
        bf_cnt_q <= bf_cnt_q + 16'h1;
      end
      if (O_UPSTREAM_TRIP) bf_q <= 1'b1;
      else if (clr_bf) bf_q <= 1'b0;
    end
  end
  assign O_BREAKER_FAIL_ALARM = bf_q;

  // ---------------------------------------------------------------
  // Maintenance monitor
  // ---------------------------------------------------------------
  logic [15:0] wear;
  assign wear = 16'((i_max >> MAINT_SHIFT) + 16'h1);  // Heavier current wears more

  // Software load wins; counter floors at zero
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      maint_q <= R_MAINT;
    end else if (wr_en && addr == A_MAINT && I_AVS_BYTEENABLE[1:0] == 2'b11) begin
      maint_q <= I_AVS_WRITEDATA[15:0];
    end else if (brk_opened) begin
      maint_q <= (maint_q > wear) ? 16'(maint_q - wear) : 16'h0;
    end
  end
  assign O_MAINT_ALARM    = maint_q == 16'h0;
  assign O_MAINT_PREALARM = maint_q <= pre_q;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    rdata = 32'h0;
    if (addr < A_CFG) rdata = stage_q[addr[5:2]];
    if (addr >= A_DEAD0 && addr < A_ROUTE) rdata = dead_q[3'(addr[7:2] - A_DEAD0[7:2])];
    case (addr)
      A_CFG:    rdata = cfg_q;
      A_ANGLE:  rdata = angle_q;
      A_DEBLK:  rdata = deblk_q;
      A_ROUTE:  rdata = route_q;
      A_MAINT:  rdata = {pre_q, maint_q};
      A_BFAIL:  rdata = bfail_q;
      A_STATUS: rdata = {1'b0, O_MAINT_PREALARM, O_MAINT_ALARM, bf_q, def_q,
                         shot_q, st_q, trips, starts};
      default:  ;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_AVS_READDATA <= '0;
    end else if (I_AVS_READ && !done_q) begin
      O_AVS_READDATA <= rdata;
    end
  end

endmodule : fpr_top

/* test/fpr_asserts.sv */
// Port-level checks of the feeder protection block
`timescale 1ns/1ps
module fpr_asserts (
  // Clock, reset and bus
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic O_AVS_WAITREQUEST,
  // Breaker, reclose and alarm pins
  input wire logic I_EXTERNAL_CONTROL_TWO,
  input wire logic I_BREAKER_POSITION_INPUT,
  input wire logic O_BREAKER_CLOSE_OUTPUT,
  input wire logic O_RECLOSE_BUSY,
  input wire logic O_DEFINITE_TRIP_INDICATOR,
  input wire logic O_BREAKER_FAIL_ALARM,
  input wire logic O_MAINT_ALARM,
  input wire logic O_MAINT_PREALARM
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // Every request costs exactly one wait cycle
  sequence seq_one_wait;
    O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
  endsequence
  chk_bus_wait: assert property ($rose(I_AVS_READ || I_AVS_WRITE) |-> seq_one_wait)
    else $error("bus wait not one cycle");
  chk_bus_idle: assert property (!I_AVS_READ && !I_AVS_WRITE |-> !O_AVS_WAITREQUEST)
    else $error("wait raised without request");
  // Close only inside a sequence, never against the close-inhibit pin (ext two)
  chk_close_busy: assert property (O_BREAKER_CLOSE_OUTPUT |-> O_RECLOSE_BUSY)
    else $error("close outside sequence");
  chk_close_inhibit: assert property (I_EXTERNAL_CONTROL_TWO [*4] |-> !O_BREAKER_CLOSE_OUTPUT)
    else $error("close while inhibited");
  chk_close_open: assert property ($rose(O_BREAKER_CLOSE_OUTPUT)
    |-> $past(I_BREAKER_POSITION_INPUT, 3)) else $error("close before breaker open");
  // Alarms hold until software clears them
  chk_def_sticky: assert property (O_DEFINITE_TRIP_INDICATOR && !I_AVS_WRITE
    |=> O_DEFINITE_TRIP_INDICATOR) else $error("definite trip dropped");
  chk_bf_sticky: assert property (O_BREAKER_FAIL_ALARM && !I_AVS_WRITE
    |=> O_BREAKER_FAIL_ALARM) else $error("breaker fail alarm dropped");
  chk_maint_pre: assert property (O_MAINT_ALARM |-> O_MAINT_PREALARM)
    else $error("alarm without prealarm");
endmodule : fpr_asserts
bind fpr_top fpr_asserts fpr_asserts_i (.*);

/* test/fpr_breaker.sv */
// Circuit breaker model driven by the trip and close relays
`timescale 1ns/1ps
module fpr_breaker (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Relay commands
  input  wire logic i_trip,
  input  wire logic i_close,
  // Position, high while open
  output logic      o_open
);
  // Trip wins over close, so a standing trip keeps it open
  always_ff @(posedge i_clk) begin
    if (i_rst) o_open <= 1'b0;
    else if (i_trip) o_open <= 1'b1;
    else if (i_close) o_open <= 1'b0;
  end
endmodule : fpr_breaker

/* test/tb_top.sv */
// Self-checking bench of the feeder protection block
`timescale 1ns/1ps
module tb_top
  import fpr_pkg::*;
;
  logic        I_SYS_CLK = 1'b0;
  logic        I_RST = 1'b1;
  logic [15:0] cur = 16'h0000;
  logic [15:0] ef = 16'h0000;
  logic [3:0]  be = 4'hf;
  logic        sto;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0, wr = 1'b0, ext2 = 1'b0, inh = 1'b0, ctl = 1'b0;
  logic [31:0] wd = 32'h0, q, rdata;
  logic        wq, trip1, close, busy, def, pre, brk;
  logic [3:0]  src;
  int          miscompares = 0, compares = 0, cyc = 0;
  // ------------------------------------------------------------
  // Clock, design and breaker
  // ------------------------------------------------------------
  always #10 I_SYS_CLK = ~I_SYS_CLK;
  fpr_top #(.TICK_CNT(10)) fpr_top_i (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
    .I_PHASE_CUR_A(cur), .I_PHASE_CUR_B(cur), .I_PHASE_CUR_C(cur),
    .I_NEUTRAL_CUR(ef), .I_NEUTRAL_CUR_SENS(16'h0000), .I_RESIDUAL_VOLT(16'h0000),
    .I_RESIDUAL_ANGLE(9'h000), .I_EXTERNAL_CONTROL_ONE(1'b0), .I_EXTERNAL_CONTROL_TWO(ext2),
    .I_BREAKER_POSITION_INPUT(brk), .I_RECLOSE_INHIBIT_INPUT(inh),
    .I_RECLOSE_CONTROL_INPUT(ctl), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wq), .O_HEAVY_TRIP_OUTPUT_ONE(trip1), .O_HEAVY_TRIP_OUTPUT_TWO(),
    .O_UPSTREAM_TRIP(), .O_BREAKER_CLOSE_OUTPUT(close), .O_START_SIGNAL(sto),
    .O_RECLOSE_BUSY(busy), .O_DEFINITE_TRIP_INDICATOR(def), .O_BREAKER_FAIL_ALARM(),
    .O_DEFINITE_SOURCE(src), .O_MAINT_ALARM(), .O_MAINT_PREALARM(pre),
    .O_SELF_SUPERVISION_OUTPUT());
  fpr_breaker fpr_breaker_i (.i_clk(I_SYS_CLK), .i_rst(I_RST), .i_trip(trip1),
    .i_close(close), .o_open(brk));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Request held until the rising edge that sees waitrequest low, data taken there
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge I_SYS_CLK);
    adr <= a; rd <= !w; wr <= w; wd <= d;
    do @(posedge I_SYS_CLK); while (wq !== 1'b0);
    q = rdata; rd <= 1'b0; wr <= 1'b0;
  endtask : bus
  task ms(input int n);
    repeat (n * 10) @(posedge I_SYS_CLK);
  endtask : ms
  task wrap_up;
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Hang guard at 500 ticks, far above the fewer than a hundred ticks of the run
  always @(posedge I_SYS_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up;
    end
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge I_SYS_CLK);
    I_RST <= 1'b0;
    bus(8'hfc, 1'b0, 32'h0); chk("unmapped", q, 32'h0);
    bus(A_CFG, 1'b0, 32'h0); chk("cfg", q, R_CFG);
    bus(A_STAGE0, 1'b1, 32'h0014_0064);
    bus(A_DEAD0, 1'b1, 32'h0002_0005);  // Shot one: overcurrent start, 5 ms dead
    bus(A_MAINT, 1'b1, 32'h0064_0065);
    ext2 <= 1'b1; cur <= 16'h00c8;
    ms(1); bus(A_STATUS, 1'b0, 32'h0); chk("start", q[0], 1'b1);
    chk("opened", brk, 1'b1); chk("busy", busy, 1'b1);
    ms(5); chk("inhibited", close, 1'b0);
    ext2 <= 1'b0;
    for (int k = 0; k < 200 && close !== 1'b1; k++) @(posedge I_SYS_CLK);
    chk("close", close, 1'b1);
    for (int k = 0; k < 400 && def !== 1'b1; k++) @(posedge I_SYS_CLK);
    chk("definite", def, 1'b1); chk("source", src, 4'h2);
    ms(1); chk("final idle", busy, 1'b0); chk("prealarm", pre, 1'b1);
    bus(A_CFG, 1'b1, 32'h0000_1001); bus(A_STATUS, 1'b1, 32'h0800_0000);
    ms(25); chk("blocked", trip1, 1'b0);
    bus(A_STATUS, 1'b0, 32'h0); chk("blocked st", q[17:0], 18'h0);
    inh <= 1'b1; ctl <= 1'b1;
    bus(A_CFG, 1'b1, 32'h0000_1000);
    ms(25); chk("trip", trip1, 1'b1); chk("refused", busy, 1'b0);
    chk("def cleared", def, 1'b0);
    bus(A_STAGE0 + 8'h0c, 1'b1, 32'h0005_0010); bus(A_ROUTE, 1'b1, 32'h0020_01ff);
    ef <= 16'h0020; ms(7); bus(A_STATUS, 1'b0, 32'h0);
    chk("ef start", q[3], 1'b1); chk("ef trip", q[12], 1'b1);
    chk("start out", sto, 1'b1);
    be <= 4'hc; bus(A_MAINT, 1'b1, 32'h0032_0000); be <= 4'hf;
    bus(A_MAINT, 1'b0, 32'h0); chk("maint", q, 32'h0032_0063);
    chk("prealarm off", pre, 1'b0);
    wrap_up;
  end
endmodule : tb_top
